// [core/rbc_pkg.sv]
// Constants, register layout and state types of the receiver bit check core
// ****************************************************************
// Summary of operation
// ****************************************************************
// Summary of operation
// - Bits to verify selectable as 0, 3, 6 or 9, giving 0..18 interval checks.
// - Every bit counts as two consecutive edge-to-edge interval checks.
// - Edge with interval inside the window passes the check and verifying continues.
// - Edge below lower limit, or counter reaching upper limit, aborts to sleep.
// - Lower window is lower value ticks; upper is upper value minus one ticks.
// - Lower and upper window limits are separate 5-bit fields of the limit word.
// - Unprogrammed window limits default to 14 lower and 24 upper.
// - Interval counter advances per extended tick; demodulator ignored during startup.
// - All bits passed enters receive mode and drives processed data onto data pin.
// - Receive mode lasts until explicitly commanded back to polling.
// - Demodulator sampled on extended tick, so data edges fall on tick boundaries.
// - After each output edge that follows the demodulator, level frozen for in-window or out-of-window hold time; the forced release sets no hold.
// - Data output low time capped even while the demodulator stays low.
// - Off command is a transfer with first bit one and a single sync pulse.
// - Completing the off command starts the programmed sleep interval.
// - Low pulse on enable pin starts the sleep interval after its rising edge.
// - Device stays asleep while the enable pin is held low.
// - First falling edge on the data pin in receive mode serves as wake-up.
// - Extended tick period depends on the baud band in the operating word.
// - Baud band codes 00..11 select scale factor 8, 4, 2, 1; 00 default.
// - Sleep lasts sleep field times extension factor times 1024 base ticks, except sleep field 31, which never ends.
// - Programming word with first bit one acts as off command, second bit ignored.
package rbc_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int T_CLK_PS = 2038300;
    localparam int BASE_TICK_CYCLES = T_CLK_PS / CLK_PERIOD_PS;
    localparam int SLEEP_UNIT_SHIFT = 10;
    localparam int SLEEP_EXT_SHIFT = 3;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [3:0] ADDR_OPCFG = 4'h0;
    localparam logic [3:0] ADDR_LIMIT = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // Operating configuration word fields
    localparam int OP_BAUD_LSB = 0;
    localparam int OP_NBITS_LSB = 2;
    localparam int OP_SLEEP_LSB = 4;
    localparam int OP_XSTD_BIT = 9;
    localparam int OP_XTEMP_BIT = 10;
    localparam int OP_POUT_BIT = 11;
    localparam logic [1:0] BAUD_RST = 2'h0;
    localparam logic [1:0] NBITS_RST = 2'h2;
    localparam logic [4:0] SLEEP_RST = 5'h0B;
    localparam logic [4:0] SLEEP_PERMANENT = 5'h1F;

    // Limit word fields
    localparam int LIM_MIN_LSB = 0;
    localparam int LIM_MAX_LSB = 8;
    localparam logic [4:0] LIM_MIN_RST = 5'h0E;
    localparam logic [4:0] LIM_MAX_RST = 5'h18;

    // Status word fields
    localparam int ST_MODE_LSB = 0;
    localparam int ST_DATA_BIT = 4;
    localparam int ST_OFF_LSB = 5;
    localparam int ST_PASS_LSB = 8;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_SLEEP = 2'b00,
        MODE_STARTUP = 2'b01,
        MODE_CHECK = 2'b10,
        MODE_RECEIVE = 2'b11
    } rbc_mode_t;

    typedef enum logic [1:0] {
        OFF_IDLE = 2'b00,
        OFF_LOW = 2'b01,
        OFF_GAP = 2'b10,
        OFF_SYNC = 2'b11
    } rbc_off_t;

endpackage : rbc_pkg

// [core/rbc_core.sv]
// Bit check, data gate and polling control of the receiver digital core
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rbc_core #(
    parameter int BASE_CYCLES = rbc_pkg::BASE_TICK_CYCLES,
    parameter int STARTUP_TICKS = 16,
    parameter int HOLD_IN_TICKS = 6,
    parameter int HOLD_OUT_TICKS = 8,
    parameter int LOW_MAX_TICKS = 60,
    parameter int OFF_LOW_TICKS = 100,
    parameter int SYNC_TICKS = 10,
    parameter int GAP_MAX_TICKS = 200
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Demodulator and host pins
    input wire logic dem_i,
    input wire logic enable_i,
    input wire logic data_i,
    output logic data_o,
    output logic data_oe_n_o,
    output logic pout_o,
    output rbc_pkg::rbc_mode_t mode_o
);
    import rbc_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [1:0] baud;
        logic [1:0] nbits;
        logic [4:0] sleep;
        logic xstd;
        logic xtemp;
        logic pout;
        logic [4:0] lim_min;
        logic [4:0] lim_max;
        logic [8:0] base_cnt;
        logic [2:0] x_cnt;
        rbc_mode_t mode;
        logic [17:0] sleep_cnt;
        logic [7:0] start_cnt;
        logic [5:0] cv;
        logic [4:0] passes;
        logic dem_sync;
        logic out;
        logic [5:0] hold;
        logic [7:0] low_cnt;
        logic low_block;
        rbc_off_t off;
        logic [7:0] off_cnt;
    } rbc_state_t;

    rbc_state_t state_reg;
    rbc_state_t state_next;

    logic base_tick;
    logic x_tick;
    logic [2:0] scale_m1;
    logic [4:0] need;
    logic [17:0] sleep_load;
    logic drive_low;
    logic line_low;
    logic edge_seen;
    logic in_window;
    logic sel_opcfg;
    logic sel_limit;
    logic sel_status;
    logic [31:0] opcfg_word;
    logic [31:0] limit_word;
    logic [31:0] status_word;

    // ****************************************************************
    // Derived terms
    // ****************************************************************
    always_comb begin
        base_tick = (state_reg.base_cnt == 9'(BASE_CYCLES - 1));
        unique case (state_reg.baud)
            2'b00: scale_m1 = 3'h7;
            2'b01: scale_m1 = 3'h3;
            2'b10: scale_m1 = 3'h1;
            2'b11: scale_m1 = 3'h0;
        endcase
        x_tick = base_tick && (state_reg.x_cnt == scale_m1);
        unique case (state_reg.nbits)
            2'b00: need = 5'h00;
            2'b01: need = 5'h06;
            2'b10: need = 5'h0C;
            2'b11: need = 5'h12;
        endcase
        // Sleep field scaled by 1024 base ticks, times eight when extended
        sleep_load = 18'({state_reg.sleep, 10'h000});
        if (state_reg.xstd || state_reg.xtemp) begin
            sleep_load = 18'({state_reg.sleep, 13'h0000});
        end
        // Only low is driven; high is left to the pull-up so the host can override
        drive_low = (state_reg.mode == MODE_RECEIVE) && !state_reg.out
            && (state_reg.off == OFF_IDLE);
        line_low = !data_i && !drive_low;
        edge_seen = (dem_i != state_reg.dem_sync);
        // Upper window is one tick short of the limit value itself
        in_window = (state_reg.cv >= {1'b0, state_reg.lim_min})
            && (state_reg.cv < {1'b0, state_reg.lim_max});
        sel_opcfg = (avs_address_i == ADDR_OPCFG);
        sel_limit = (avs_address_i == ADDR_LIMIT);
        sel_status = (avs_address_i == ADDR_STATUS);
        opcfg_word = '0;
        opcfg_word[OP_BAUD_LSB +: 2] = state_reg.baud;
        opcfg_word[OP_NBITS_LSB +: 2] = state_reg.nbits;
        opcfg_word[OP_SLEEP_LSB +: 5] = state_reg.sleep;
        opcfg_word[OP_XSTD_BIT] = state_reg.xstd;
        opcfg_word[OP_XTEMP_BIT] = state_reg.xtemp;
        opcfg_word[OP_POUT_BIT] = state_reg.pout;
        limit_word = '0;
        limit_word[LIM_MIN_LSB +: 5] = state_reg.lim_min;
        limit_word[LIM_MAX_LSB +: 5] = state_reg.lim_max;
        status_word = '0;
        status_word[ST_MODE_LSB +: 2] = state_reg.mode;
        status_word[ST_DATA_BIT] = state_reg.out;
        status_word[ST_OFF_LSB +: 2] = state_reg.off;
        status_word[ST_PASS_LSB +: 5] = state_reg.passes;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        state_next = state_reg;

        // Bus: one wait cycle, then the access completes
        state_next.ack = (avs_read_i || avs_write_i) && !state_reg.ack;
        if (avs_read_i && !state_reg.ack) begin
            state_next.rdata = '0;
            if (sel_opcfg) begin
                state_next.rdata = opcfg_word;
            end else if (sel_limit) begin
                state_next.rdata = limit_word;
            end else if (sel_status) begin
                state_next.rdata = status_word;
            end
        end

        // Tick dividers
        state_next.base_cnt = base_tick ? 9'h000 : state_reg.base_cnt + 9'h001;
        if (base_tick) begin
            state_next.x_cnt = x_tick ? 3'h0 : state_reg.x_cnt + 3'h1;
        end

        unique case (state_reg.mode)
            MODE_SLEEP: begin
                if (base_tick && (state_reg.sleep != SLEEP_PERMANENT)) begin
                    if (state_reg.sleep_cnt == 18'h00000) begin
                        state_next.mode = MODE_STARTUP;
                        state_next.start_cnt = 8'h00;
                    end else begin
                        state_next.sleep_cnt = state_reg.sleep_cnt - 18'h00001;
                    end
                end
            end
            MODE_STARTUP: begin
                // Demodulator is unsettled here and deliberately not looked at
                if (base_tick) begin
                    state_next.start_cnt = state_reg.start_cnt + 8'h01;
                    if (state_reg.start_cnt == 8'(STARTUP_TICKS - 1)) begin
                        state_next.cv = 6'h00;
                        state_next.passes = 5'h00;
                        state_next.dem_sync = dem_i;
                        state_next.mode = (need == 5'h00) ? MODE_RECEIVE : MODE_CHECK;
                        state_next.out = 1'b1;
                        state_next.hold = 6'h00;
                        state_next.low_cnt = 8'h00;
                        state_next.low_block = 1'b0;
                        state_next.off = OFF_IDLE;
                    end
                end
            end
            MODE_CHECK: begin
                if (x_tick) begin
                    state_next.dem_sync = dem_i;
                    if (edge_seen) begin
                        if (state_reg.cv < {1'b0, state_reg.lim_min}) begin
                            state_next.mode = MODE_SLEEP;
                            state_next.sleep_cnt = sleep_load;
                            state_next.passes = 5'h00;
                            state_next.xtemp = 1'b0;
                        end else begin
                            state_next.passes = state_reg.passes + 5'h01;
                            state_next.cv = 6'h00;
                            if (state_reg.passes + 5'h01 == need) begin
                                state_next.mode = MODE_RECEIVE;
                            end
                        end
                    end else if (state_reg.cv + 6'h01 >= {1'b0, state_reg.lim_max}) begin
                        state_next.mode = MODE_SLEEP;
                        state_next.sleep_cnt = sleep_load;
                        state_next.passes = 5'h00;
                        state_next.xtemp = 1'b0;
                    end else begin
                        state_next.cv = state_reg.cv + 6'h01;
                    end
                end
            end
            MODE_RECEIVE: begin
                // Only the off command or enable low leaves; the data stream never does
                if (x_tick) begin
                    state_next.dem_sync = dem_i;
                    if (state_reg.cv != 6'h3F) begin
                        state_next.cv = state_reg.cv + 6'h01;
                    end
                    if (state_reg.hold != 6'h00) begin
                        state_next.hold = state_reg.hold - 6'h01;
                    end
                    if (dem_i) begin
                        state_next.low_block = 1'b0;
                    end
                    if (!state_reg.out) begin
                        state_next.low_cnt = state_reg.low_cnt + 8'h01;
                    end
                    if (!state_reg.out && (state_reg.low_cnt == 8'(LOW_MAX_TICKS - 1))) begin
                        // Forced release keeps the line free for the host
                        state_next.out = 1'b1;
                        state_next.low_block = 1'b1;
                        state_next.low_cnt = 8'h00;
                        state_next.cv = 6'h00;
                    end else if ((state_reg.hold == 6'h00) && (dem_i != state_reg.out)
                        && !(state_reg.low_block && !dem_i)) begin
                        state_next.out = dem_i;
                        state_next.low_cnt = 8'h00;
                        state_next.cv = 6'h00;
                        state_next.hold = in_window ? 6'(HOLD_IN_TICKS) : 6'(HOLD_OUT_TICKS);
                    end
                end
                // Off command on the data line, measured in base ticks
                if (base_tick) begin
                    unique case (state_reg.off)
                        OFF_IDLE: begin
                            if (line_low) begin
                                state_next.off = OFF_LOW;
                                state_next.off_cnt = 8'h00;
                            end
                        end
                        OFF_LOW: begin
                            if (line_low) begin
                                if (state_reg.off_cnt != 8'hFF) begin
                                    state_next.off_cnt = state_reg.off_cnt + 8'h01;
                                end
                            end else if (state_reg.off_cnt >= 8'(OFF_LOW_TICKS - 1)) begin
                                state_next.off = OFF_GAP;
                                state_next.off_cnt = 8'h00;
                            end else begin
                                state_next.off = OFF_IDLE;
                            end
                        end
                        OFF_GAP: begin
                            // First bit one means one sync pulse and nothing after
                            if (line_low) begin
                                state_next.off = OFF_SYNC;
                                state_next.off_cnt = 8'h00;
                            end else if (state_reg.off_cnt == 8'(GAP_MAX_TICKS - 1)) begin
                                state_next.off = OFF_IDLE;
                            end else begin
                                state_next.off_cnt = state_reg.off_cnt + 8'h01;
                            end
                        end
                        OFF_SYNC: begin
                            if (line_low) begin
                                if (state_reg.off_cnt != 8'hFF) begin
                                    state_next.off_cnt = state_reg.off_cnt + 8'h01;
                                end
                            end else if (state_reg.off_cnt >= 8'(SYNC_TICKS - 1)) begin
                                state_next.off = OFF_IDLE;
                                state_next.mode = MODE_SLEEP;
                                state_next.sleep_cnt = sleep_load;
                                state_next.out = 1'b1;
                            end else begin
                                state_next.off = OFF_IDLE;
                            end
                        end
                    endcase
                end
            end
        endcase

        // Enable low holds sleep with the counter preloaded; release starts it
        if (!enable_i) begin
            state_next.mode = MODE_SLEEP;
            state_next.sleep_cnt = sleep_load;
            state_next.off = OFF_IDLE;
            state_next.out = 1'b1;
            state_next.passes = 5'h00;
        end

        // Register writes complete on the edge where waitrequest is low
        if (avs_write_i && state_reg.ack) begin
            if (sel_opcfg) begin
                state_next.baud = avs_writedata_i[OP_BAUD_LSB +: 2];
                state_next.nbits = avs_writedata_i[OP_NBITS_LSB +: 2];
                state_next.sleep = avs_writedata_i[OP_SLEEP_LSB +: 5];
                state_next.xstd = avs_writedata_i[OP_XSTD_BIT];
                state_next.xtemp = avs_writedata_i[OP_XTEMP_BIT];
                state_next.pout = avs_writedata_i[OP_POUT_BIT];
            end else if (sel_limit) begin
                state_next.lim_min = avs_writedata_i[LIM_MIN_LSB +: 5];
                state_next.lim_max = avs_writedata_i[LIM_MAX_LSB +: 5];
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.baud <= BAUD_RST;
            state_reg.nbits <= NBITS_RST;
            state_reg.sleep <= SLEEP_RST;
            state_reg.lim_min <= LIM_MIN_RST;
            state_reg.lim_max <= LIM_MAX_RST;
            state_reg.mode <= MODE_SLEEP;
            state_reg.off <= OFF_IDLE;
            state_reg.out <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !state_reg.ack;
    assign avs_readdata_o = state_reg.rdata;
    assign data_o = 1'b0;
    assign data_oe_n_o = !drive_low;
    assign pout_o = state_reg.pout;
    assign mode_o = state_reg.mode;

endmodule : rbc_core
`default_nettype wire

// [dv/rbc_core_sva.sv]
// Assertion checker for the receiver bit check core
`timescale 1ns/1ps
`default_nettype none
module rbc_core_sva import rbc_pkg::*; #(
    parameter int BASE_CYCLES = 4,
    parameter int LOW_MAX_TICKS = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic enable_i,
    input wire logic data_oe_n_o,
    input wire logic pout_o,
    input wire rbc_pkg::rbc_mode_t mode_o
);
    // Slowest band has eight base ticks per extended tick, so the cap holds for all bands
    localparam int LOW_CAP = (LOW_MAX_TICKS + 2) * 8 * BASE_CYCLES;
    logic [15:0] low_cnt;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt <= 16'h0;
        end else if (data_oe_n_o) begin
            low_cnt <= 16'h0;
        end else begin
            low_cnt <= low_cnt + 16'h1;
        end
    end
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wait_first_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
        else $error("waitrequest low in first request cycle");
    wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("more than one wait cycle");
    limit_field_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == ADDR_LIMIT
        |-> avs_readdata_o[31:13] == 19'h0 && avs_readdata_o[7:5] == 3'h0)
        else $error("limit word bits outside fields set");
    pout_write_a: assert property ($changed(pout_o)
        |-> $past(avs_write_i && !avs_waitrequest_o && avs_address_i == ADDR_OPCFG))
        else $error("pout changed without opcfg write");
    gate_receive_a: assert property (!data_oe_n_o |-> mode_o == MODE_RECEIVE)
        else $error("data pin driven outside receive");
    enable_sleep_a: assert property (!enable_i |=> mode_o == MODE_SLEEP)
        else $error("not asleep while enable low");
    sleep_startup_a: assert property ($past(mode_o) == MODE_SLEEP && mode_o != MODE_SLEEP
        |-> mode_o == MODE_STARTUP) else $error("sleep left without startup");
    low_hold_a: assert property (disable iff (rst_i || !enable_i)
        $fell(data_oe_n_o) |=> !data_oe_n_o [*8]) else $error("low level not held");
    low_cap_a: assert property (low_cnt <= LOW_CAP) else $error("data low too long");
    cover property (mode_o == MODE_RECEIVE);
    cover property ($fell(data_oe_n_o));
    cover property ($past(mode_o) == MODE_CHECK && mode_o == MODE_SLEEP);
endmodule : rbc_core_sva
bind rbc_core rbc_core_sva #(.BASE_CYCLES(BASE_CYCLES), .LOW_MAX_TICKS(LOW_MAX_TICKS)) u_sva (
    .clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
    .avs_waitrequest_o, .enable_i, .data_oe_n_o, .pout_o, .mode_o);
`default_nettype wire

// [dv/rbc_host_mdl.sv]
// Host controller model on the open-drain data line and the enable pin
`timescale 1ns/1ps
`default_nettype none
module rbc_host_mdl #(
    parameter int BASE = 4
) (
    input wire logic clk_i,
    input wire logic dev_oe_n_i,
    output logic line_o,
    output var logic enable_o = 1'b1
);
    logic host_pull = 1'b0;
    // Pull-up: the line is low only while some party pulls it
    assign line_o = !(host_pull || !dev_oe_n_i);
    task automatic hold_low(input int ticks);
        @(posedge clk_i);
        host_pull <= 1'b1;
        repeat (ticks * BASE) @(posedge clk_i);
        host_pull <= 1'b0;
    endtask : hold_low
    // Off transfer: long low, a gap, then one sync pulse only
    task automatic off_cmd(input int t_low, input int t_gap, input int t_sync);
        hold_low(t_low);
        repeat (t_gap * BASE) @(posedge clk_i);
        hold_low(t_sync);
    endtask : off_cmd
    task automatic doze(input int cycles);
        @(posedge clk_i);
        enable_o <= 1'b0;
        repeat (cycles) @(posedge clk_i);
        enable_o <= 1'b1;
    endtask : doze
endmodule : rbc_host_mdl
`default_nettype wire

// [dv/tb_rbc_core.sv]
// Self-checking testbench of the receiver bit check core
`timescale 1ns/1ps
`default_nettype none
module tb_rbc_core;
    import rbc_pkg::*;
    localparam int XT = 4; // Base cycles, equal to one extended tick at band 3
    typedef struct {logic [3:0] a; logic [31:0] wd; logic [31:0] rd; logic po;} rbc_row_t;
    logic clk_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0, dem_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
    logic avs_waitrequest_o, enable_i, data_i, data_oe_n_o, pout_o, saw_low = 1'b0;
    rbc_mode_t mode_o;
    int n_errors = 0, check_count = 0;
    rbc_row_t rows [6] = '{'{ADDR_LIMIT, 32'hFFFF_FFFF, 32'h0000_1F1F, 1'b0},
        '{ADDR_LIMIT, 32'h0000_140A, 32'h0000_140A, 1'b0},
        '{ADDR_OPCFG, 32'hFFFF_FFFF, 32'h0000_0FFF, 1'b1},
        '{4'hC, 32'h0000_1234, 32'h0000_0000, 1'b1},
        '{ADDR_LIMIT, 32'h0000_180E, 32'h0000_180E, 1'b1},
        '{ADDR_OPCFG, 32'h0000_0017, 32'h0000_0017, 1'b0}};
    always #2.5 clk_i = ~clk_i;
    rbc_core #(.BASE_CYCLES(XT), .LOW_MAX_TICKS(20), .OFF_LOW_TICKS(8), .SYNC_TICKS(2)) DUT (
        .clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_readdata_o, .avs_waitrequest_o, .dem_i, .enable_i, .data_i, .data_o(),
        .data_oe_n_o, .pout_o, .mode_o);
    rbc_host_mdl host (.clk_i, .dev_oe_n_i(data_oe_n_o), .line_o(data_i),
        .enable_o(enable_i));
    always @(posedge clk_i) if (data_oe_n_o === 1'b0) saw_low <= 1'b1;
    task automatic summarize();
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic check_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h got %h", nm, exp, got);
        end
    endtask : check_word
    task automatic check_mode(input string nm, input rbc_mode_t exp);
        check_count++;
        if (mode_o !== exp) begin
            n_errors++;
            $display("Error %s expected %b got %b", nm, exp, mode_o);
        end
    endtask : check_mode
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int k = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0 && ++k < 20);
        if (k >= 20) n_errors++;
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : xfer
    task automatic wait_mode(input rbc_mode_t m, input int lim);
        for (int k = 0; k < lim && mode_o !== m; k++) @(posedge clk_i);
    endtask : wait_mode
    task automatic run_dem(input int n, input int half);
        repeat (n) begin
            repeat (half * XT) @(posedge clk_i);
            dem_i <= ~dem_i;
        end
    endtask : run_dem
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].a, rows[i].wd);
            xfer(1'b0, rows[i].a, 32'h0);
            check_word("readback", rows[i].rd, rd);
            check_word("pout", {31'h0, rows[i].po}, {31'h0, pout_o});
        end
        $display("Test register table done");
        wait_mode(MODE_SLEEP, 2000);
        wait_mode(MODE_CHECK, 6000);
        run_dem(1, 5);
        wait_mode(MODE_SLEEP, 4 * XT);
        check_mode("early edge", MODE_SLEEP);
        wait_mode(MODE_CHECK, 6000);
        repeat (21 * XT) @(posedge clk_i);
        check_mode("inside window", MODE_CHECK);
        wait_mode(MODE_SLEEP, 4 * XT);
        check_mode("upper limit", MODE_SLEEP);
        $display("Test abort done");
        wait_mode(MODE_CHECK, 6000);
        run_dem(7, 18);
        check_mode("receive entry", MODE_RECEIVE);
        repeat (2 * XT) @(posedge clk_i);
        check_word("wake edge", 32'h1, {31'h0, saw_low});
        repeat (30 * XT) @(posedge clk_i);
        check_word("low cap", 32'h1, {31'h0, data_oe_n_o});
        check_mode("receive hold", MODE_RECEIVE);
        dem_i <= 1'b1;
        repeat (4 * XT) @(posedge clk_i);
        host.off_cmd(10, 3, 3);
        wait_mode(MODE_SLEEP, 2 * XT);
        check_mode("off command", MODE_SLEEP);
        $display("Test receive done");
        wait_mode(MODE_CHECK, 6000);
        host.doze(20);
        repeat (10 * XT) @(posedge clk_i);
        check_mode("doze", MODE_SLEEP);
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        xfer(1'b0, ADDR_OPCFG, 32'h0);
        check_word("opcfg default", 32'h0000_00B8, rd);
        xfer(1'b0, ADDR_LIMIT, 32'h0);
        check_word("limit default", 32'h0000_180E, rd);
        xfer(1'b1, ADDR_OPCFG, 32'h0000_0003);
        host.doze(8);
        wait_mode(MODE_STARTUP, 2 * XT);
        check_mode("instant poll", MODE_STARTUP);
        wait_mode(MODE_RECEIVE, 80);
        check_mode("no bit check", MODE_RECEIVE);
        $display("Test doze and reset done");
        summarize();
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        n_errors++;
        summarize();
    end
endmodule : tb_rbc_core
`default_nettype wire
